// ==== src/slot_decode_pkg.sv ====
// Purpose: Shared constants for the shared-slot host decode block.
// Assumes: Byte addresses on a 26-bit slot address plus region selects.
// Notes: Offsets, window limits, region sizes, strap values, alias counts and pacing are named here once.
package slot_decode_pkg;
    // Window decode inside one controller alias
    localparam int unsigned WIN_ADDR_W = 17;
    localparam logic [16:0] MEM_LAST = 17'h1_3FFF;
    localparam logic [16:0] REG_FIRST = 17'h1_FFE0;
    localparam logic [16:0] REG_LAST = 17'h1_FFFF;
    // Buffered map, slot 1 and slot 2
    localparam logic [31:0] S1_CARD_IO = 32'h0800_0000;
    localparam logic [31:0] S1_CTRL = 32'h0900_0000;
    localparam logic [31:0] S1_CARD_ATTR = 32'h0A00_0000;
    localparam logic [31:0] S2_CARD_IO = 32'h0C00_0000;
    localparam logic [31:0] S2_CTRL = 32'h0D00_0000;
    localparam logic [31:0] S2_CARD_ATTR = 32'h0E00_0000;
    // Direct map, slot memory spaces
    localparam logic [31:0] S1_DIRECT = 32'h6400_0000;
    localparam logic [31:0] S2_DIRECT = 32'h6800_0000;
    // Region sizes as address bits to compare (16M = 24 bits, 32M = 25, 64M = 26)
    localparam int unsigned SZ16M_BITS = 24;
    localparam int unsigned SZ32M_BITS = 25;
    localparam int unsigned SZ64M_BITS = 26;
    // Alias counts
    localparam int unsigned BUF_ALIASES = 128;
    localparam int unsigned DIRECT_ALIASES = 512;
    // Strap field values
    localparam logic [2:0] BUS_GENERIC = 3'h7;
    localparam logic STATUS_MODE_TWO = 1'h1;
    // Access pacing: cycles the wait output is held before data is good
    localparam int unsigned ACCESS_NS = 75;
    localparam int unsigned CLK_NS = 25;
    localparam logic [2:0] ACCESS_CYC = 3'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    // Region kinds
    typedef enum logic [2:0] {
        REGION_NONE = 3'h0,
        REGION_CARD_IO = 3'h1,
        REGION_CTRL = 3'h2,
        REGION_CARD_ATTR = 3'h3,
        REGION_DIRECT = 3'h4
    } region_e;
    // Access state: idle, wait, done, hold along a Gray path
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b11,
        ST_HOLD = 2'b10
    } access_state_e;
endpackage : slot_decode_pkg

// ==== src/strobe_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous active-low strobes.
// Assumes: Strobes idle high; reset releases to idle.
// Notes: First stage feeds only the second stage.
`timescale 1ns/100ps
module strobe_sync (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [4:0] raw_n_in,
    output logic [4:0] sync_n_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Stage registers, metastability guard
    logic [4:0] meta_q;
    logic [4:0] meta_d;
    logic [4:0] sync_q;
    logic [4:0] sync_d;

    // Next values simply shift along
    always_comb begin
        meta_d = raw_n_in;
        sync_d = meta_q;
    end

    // Reset to idle-high so no false access appears
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_q <= 5'h1F;
            sync_q <= 5'h1F;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_n_out = sync_q;
endmodule : strobe_sync

// ==== src/strap_latch.sv ====
// Purpose: Catches configuration straps once after reset release.
// Assumes: Straps are static wires, synchronous to the clock.
// Notes: Captured by a clocked process, never by the reset itself.
`timescale 1ns/100ps
module strap_latch (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [3:0] config_straps_in,
    input wire logic bus_status_strap_in,
    output logic [3:0] straps_out,
    output logic bus_status_out,
    output logic latched_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] straps_q;
    logic [3:0] straps_d;
    logic status_q;
    logic status_d;
    logic done_q;
    logic done_d;

    // Capture only on the first edge after release, then freeze
    always_comb begin
        straps_d = straps_q;
        status_d = status_q;
        done_d = 1'b1;
        if (!done_q) begin
            straps_d = config_straps_in;
            status_d = bus_status_strap_in;
        end
    end

    // Constants under reset; the pin value arrives via the clocked path
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            straps_q <= 4'h0;
            status_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            straps_q <= straps_d;
            status_q <= status_d;
            done_q <= done_d;
        end
    end

    assign straps_out = straps_q;
    assign bus_status_out = status_q;
    assign latched_out = done_q;

    // Straps must never move after the capture
    straps_frozen_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        done_q |=> $stable(straps_q) && $stable(status_q))
        else $error("strap value changed after capture");
endmodule : strap_latch

// ==== src/shared_slot_host_decode.sv ====
// Purpose: Host-side decode, strap configuration and wait pacing for a
//          display controller sharing a card slot through a slot buffer.
// Assumes: Upper address bits arrive already latched; straps are static.
// Notes: Memory and register contents are modelled as a small local array.
// How it works
// - buffered: answer only in dedicated 16M controller region
// - synchronise strobes first, in either mode
// - buffer present ignores IO enable bits
// - slot 1 buffered map, 128 aliases
// - slot 2 buffered map, 128 aliases
// - direct map 512 aliases at 6400/6800
// - latch straps once; 111 generic, endian
// - status strap picks mode two or one
// - hold wait low until data good
// - memory 0-13FFF, registers 1FFE0-1FFFF
`timescale 1ns/100ps
module shared_slot_host_decode (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [31:0] host_addr_in,
    input wire logic buffer_present_in,
    input wire logic slot_io_space_enable_in,
    input wire logic [15:0] host_wdata_in,
    input wire logic low_byte_write_en_n_in,
    input wire logic high_byte_write_en_n_in,
    input wire logic low_byte_read_en_n_in,
    input wire logic high_byte_read_en_n_in,
    input wire logic chip_select_n_in,
    input wire logic [3:0] config_straps_in,
    input wire logic bus_status_strap_in,
    output logic [15:0] host_rdata_out,
    output logic host_wait_n_out,
    output logic ctrl_hit_out,
    output logic card_side_disable_out,
    output logic [2:0] region_out,
    output logic mode_two_out,
    output logic big_endian_out,
    output logic generic_bus_out,
    output logic reg_space_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper: compare address to a region base over a power-of-two size
    function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                       input int unsigned bits);
        logic [31:0] mask;
        mask = ~((32'h0000_0001 << bits) - 32'h0000_0001);
        in_region = ((a & mask) == (base & mask));
    endfunction : in_region

    ////////////////////////////////////////////////////////////////////////////
    // Straps and strobe synchronisation
    logic [3:0] straps;
    logic status_strap;
    logic straps_ready;
    logic [4:0] strobes_sync_n;
    logic [4:0] strobes_raw_n;

    // Straps are caught once after the reset release
    strap_latch u_straps (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .config_straps_in(config_straps_in),
        .bus_status_strap_in(bus_status_strap_in),
        .straps_out(straps),
        .bus_status_out(status_strap),
        .latched_out(straps_ready)
    );

    // Host strobes are asynchronous to our clock, so sync before use
    assign strobes_raw_n = {chip_select_n_in, high_byte_read_en_n_in, low_byte_read_en_n_in,
                            high_byte_write_en_n_in, low_byte_write_en_n_in};
    strobe_sync u_sync (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .raw_n_in(strobes_raw_n),
        .sync_n_out(strobes_sync_n)
    );

    // Decoded configuration
    logic mode_two;
    logic big_endian;
    logic generic_bus;
    always_comb begin
        generic_bus = (straps[2:0] == slot_decode_pkg::BUS_GENERIC);
        big_endian = straps[3];
        mode_two = (status_strap == slot_decode_pkg::STATUS_MODE_TWO);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Region decode of the full host address
    slot_decode_pkg::region_e region;
    always_comb begin
        region = slot_decode_pkg::REGION_NONE;
        if (buffer_present_in) begin
            // Buffered map: IO enable bit has no say here
            if (in_region(host_addr_in, slot_decode_pkg::S1_CTRL,
                          slot_decode_pkg::SZ16M_BITS) ||
                in_region(host_addr_in, slot_decode_pkg::S2_CTRL,
                          slot_decode_pkg::SZ16M_BITS)) begin
                region = slot_decode_pkg::REGION_CTRL;
            end else if (in_region(host_addr_in, slot_decode_pkg::S1_CARD_IO,
                                   slot_decode_pkg::SZ16M_BITS) ||
                         in_region(host_addr_in, slot_decode_pkg::S2_CARD_IO,
                                   slot_decode_pkg::SZ16M_BITS)) begin
                region = slot_decode_pkg::REGION_CARD_IO;
            end else if (in_region(host_addr_in, slot_decode_pkg::S1_CARD_ATTR,
                                   slot_decode_pkg::SZ32M_BITS) ||
                         in_region(host_addr_in, slot_decode_pkg::S2_CARD_ATTR,
                                   slot_decode_pkg::SZ32M_BITS)) begin
                region = slot_decode_pkg::REGION_CARD_ATTR;
            end else begin
                region = slot_decode_pkg::REGION_NONE;
            end
        end else begin
            // Direct: slot memory space always; IO/attribute space only when enable is 0
            if (in_region(host_addr_in, slot_decode_pkg::S1_DIRECT,
                          slot_decode_pkg::SZ64M_BITS) ||
                in_region(host_addr_in, slot_decode_pkg::S2_DIRECT,
                          slot_decode_pkg::SZ64M_BITS)) begin
                region = slot_decode_pkg::REGION_DIRECT;
            end else if (!slot_io_space_enable_in &&
                         (in_region(host_addr_in, slot_decode_pkg::S1_CARD_IO,
                                    slot_decode_pkg::SZ64M_BITS) ||
                          in_region(host_addr_in, slot_decode_pkg::S2_CARD_IO,
                                    slot_decode_pkg::SZ64M_BITS))) begin
                region = slot_decode_pkg::REGION_DIRECT;
            end else begin
                region = slot_decode_pkg::REGION_NONE;
            end
        end
    end

    // Controller is selected in its own region or any direct alias
    logic ctrl_sel;
    assign ctrl_sel = (region == slot_decode_pkg::REGION_CTRL) ||
                      (region == slot_decode_pkg::REGION_DIRECT);

    ////////////////////////////////////////////////////////////////////////////
    // Window decode: only the low 17 bits matter, which makes the aliases
    logic [16:0] win_addr;
    logic mem_hit;
    logic reg_hit;
    always_comb begin
        win_addr = host_addr_in[16:0];
        mem_hit = (win_addr <= slot_decode_pkg::MEM_LAST);
        reg_hit = (win_addr >= slot_decode_pkg::REG_FIRST);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Small backing store; word per even address, holes read zero
    logic [15:0] store_q [0:15];
    logic [3:0] store_idx;
    assign store_idx = win_addr[4:1];

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer with wait pacing
    slot_decode_pkg::access_state_e state_q;
    slot_decode_pkg::access_state_e state_d;
    logic [2:0] count_q;
    logic [2:0] count_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic is_write;
    logic is_read;
    logic strobe_active;
    logic do_write;

    // Mode one uses separate byte enables; mode two uses only the low enables for both
    always_comb begin
        is_write = !strobes_sync_n[0] || (!mode_two && !strobes_sync_n[1]);
        is_read = !strobes_sync_n[2] || (!mode_two && !strobes_sync_n[3]);
        strobe_active = !strobes_sync_n[4] && ctrl_sel && generic_bus && straps_ready &&
                        (is_write || is_read);
    end

    // Next-state logic: wait counts down, then one done state per access
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        rdata_d = rdata_q;
        do_write = 1'b0;
        case (state_q)
            slot_decode_pkg::ST_IDLE: begin
                if (strobe_active) begin
                    state_d = slot_decode_pkg::ST_WAIT;
                    count_d = slot_decode_pkg::ACCESS_CYC;
                end
            end
            slot_decode_pkg::ST_WAIT: begin
                if (count_q > 3'h1) begin
                    count_d = count_q - 3'h1;
                end else begin
                    state_d = slot_decode_pkg::ST_DONE;
                    do_write = is_write && (mem_hit || reg_hit);
                    rdata_d = (mem_hit || reg_hit) ? store_q[store_idx] : 16'h0000;
                end
            end
            slot_decode_pkg::ST_DONE: begin
                // Hold the answer until the host lets go of the strobe
                if (!strobe_active) begin
                    state_d = slot_decode_pkg::ST_HOLD;
                end
            end
            slot_decode_pkg::ST_HOLD: begin
                state_d = slot_decode_pkg::ST_IDLE;
            end
            default: begin
                state_d = slot_decode_pkg::ST_IDLE;
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= slot_decode_pkg::ST_IDLE;
            count_q <= 3'h0;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    // Store updates with byte lanes; lanes swap for big endian hosts in mode one only
    logic low_lane;
    logic high_lane;
    always_comb begin
        low_lane = big_endian ? !strobes_sync_n[1] : !strobes_sync_n[0];
        high_lane = big_endian ? !strobes_sync_n[0] : !strobes_sync_n[1];
        if (mode_two) begin
            low_lane = 1'b1;
            high_lane = !strobes_sync_n[1];
        end
    end
    always_ff @(posedge clock_in) begin
        if (do_write && low_lane) begin
            store_q[store_idx][7:0] <= host_wdata_in[7:0];
        end
        if (do_write && high_lane) begin
            store_q[store_idx][15:8] <= host_wdata_in[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign host_rdata_out = rdata_q;
    assign host_wait_n_out = !(state_q == slot_decode_pkg::ST_WAIT);
    assign ctrl_hit_out = ctrl_sel;
    assign card_side_disable_out = (region == slot_decode_pkg::REGION_CTRL);
    assign region_out = region;
    assign mode_two_out = mode_two;
    assign big_endian_out = big_endian;
    assign generic_bus_out = generic_bus;
    assign reg_space_out = reg_hit && ctrl_sel;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence start_s;
        state_q == slot_decode_pkg::ST_IDLE && strobe_active;
    endsequence
    sequence wait_s;
        !host_wait_n_out [*3];
    endsequence

    wait_length_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        start_s |=> wait_s ##1 host_wait_n_out)
        else $error("wait not held for the access time");
    ctrl_region_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (buffer_present_in && host_addr_in[31:24] == 8'h09) |-> ctrl_sel)
        else $error("slot 1 controller region missed");
    slot2_region_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (buffer_present_in && host_addr_in[31:24] == 8'h0D) |-> ctrl_sel)
        else $error("slot 2 controller region missed");
    card_io_quiet_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (buffer_present_in && host_addr_in[31:24] == 8'h08) |-> !ctrl_sel)
        else $error("controller answered in card io space");
    io_enable_ignored_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (buffer_present_in && $changed(slot_io_space_enable_in) && $stable(host_addr_in))
        |-> $stable(region))
        else $error("io enable changed buffered decode");
    direct_alias_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (!buffer_present_in && host_addr_in[31:26] == 6'h19) |-> ctrl_sel)
        else $error("direct slot 1 memory alias missed");
    reg_window_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (ctrl_sel && host_addr_in[16:5] == 12'hFFF) |-> reg_space_out)
        else $error("register window not decoded");
    card_hidden_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        (buffer_present_in && host_addr_in[31:24] == 8'h0D) |-> card_side_disable_out)
        else $error("card side left enabled");
    mode_select_a: assert property (@(posedge clock_in) disable iff (!arst_n_in)
        $rose(straps_ready) |-> (mode_two_out == $past(bus_status_strap_in)))
        else $error("mode does not follow status strap");
endmodule : shared_slot_host_decode

// ==== tb/host_side_model.sv ====
// Purpose: Host processor model reaching the controller through the slot buffer.
// Assumes: Mode one strobes; the buffer has already latched address bits 25 to 13.
// Notes: Released data lines show the inverse of the last value, never a stale copy.
`timescale 1ns/100ps
module host_side_model (
    input wire logic clock_in,
    input wire logic wait_n_in,
    input wire logic [15:0] rdata_in,
    output logic [31:0] addr_out,
    output logic [15:0] wdata_out,
    output logic [1:0] write_en_n_out,
    output logic [1:0] read_en_n_out,
    output logic chip_select_n_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus from time zero
    initial begin
        addr_out = 32'h0000_0000;
        wdata_out = 16'h0000;
        write_en_n_out = 2'b11;
        read_en_n_out = 2'b11;
        chip_select_n_out = 1'b1;
    end

    // Address only, for decode probing with every strobe idle
    task automatic set_addr(input logic [31:0] a);
        @(posedge clock_in);
        addr_out <= a;
    endtask : set_addr

    // One access; all is held until wait is sampled high, then released
    task automatic access(input logic [31:0] a, input logic [15:0] d, input bit wr,
                          input logic [1:0] ln, output logic [15:0] rd,
                          output int lead, output int held);
        lead = 0;
        held = 0;
        @(posedge clock_in);
        addr_out <= a;
        chip_select_n_out <= 1'b0;
        wdata_out <= wr ? d : ~wdata_out;
        write_en_n_out <= wr ? ~ln : 2'b11;
        read_en_n_out <= wr ? 2'b11 : ~ln;
        // Bounded: a refused access leaves lead at ten
        while (lead < 10) begin
            @(posedge clock_in);
            if (wait_n_in !== 1'b1) break;
            lead++;
        end
        while (wait_n_in === 1'b0 && held < 12) begin
            held++;
            @(posedge clock_in);
        end
        rd = rdata_in;
        chip_select_n_out <= 1'b1;
        write_en_n_out <= 2'b11;
        read_en_n_out <= 2'b11;
        wdata_out <= ~wdata_out;
        // Spacing before the next request
        repeat (3) @(posedge clock_in);
    endtask : access
endmodule : host_side_model

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the shared-slot host decode block.
// Assumes: Final strap reset leaves mode two, big endian, generic bus.
// Notes: Expectations come from map constants and a local word model.
`timescale 1ns/100ps
module testbench;
    logic clock_in, arst_n_in, buffer_present_in, slot_io_space_enable_in;
    logic bus_status_strap_in, cs_n, wait_n, hit, card_off, mode_two, big_end, generic, reg_sp;
    logic [3:0] config_straps_in;
    logic [31:0] host_addr, a, r;
    logic [15:0] wdata, rdata;
    logic [1:0] we_n, re_n;
    logic [2:0] region;
    logic [15:0] exp_mem [16]; // Expected storage words
    int errors, check_count, seed, i, j;

    ////////////////////////////////////////////////////////////////////////////
    shared_slot_host_decode dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .host_addr_in(host_addr), .buffer_present_in(buffer_present_in),
        .slot_io_space_enable_in(slot_io_space_enable_in), .host_wdata_in(wdata),
        .low_byte_write_en_n_in(we_n[0]), .high_byte_write_en_n_in(we_n[1]),
        .low_byte_read_en_n_in(re_n[0]), .high_byte_read_en_n_in(re_n[1]),
        .chip_select_n_in(cs_n), .config_straps_in(config_straps_in),
        .bus_status_strap_in(bus_status_strap_in), .host_rdata_out(rdata),
        .host_wait_n_out(wait_n), .ctrl_hit_out(hit), .card_side_disable_out(card_off),
        .region_out(region), .mode_two_out(mode_two), .big_endian_out(big_end),
        .generic_bus_out(generic), .reg_space_out(reg_sp));
    host_side_model host (.clock_in(clock_in), .wait_n_in(wait_n), .rdata_in(rdata),
        .addr_out(host_addr), .wdata_out(wdata), .write_en_n_out(we_n),
        .read_en_n_out(re_n), .chip_select_n_out(cs_n));

    // 40 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One comparison, counted; a mismatch is reported at once
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", name, e, g);
            errors++;
        end
    endtask : chk

    // Region per map; 7 means do not check, used where card IO owns the space
    function automatic logic [2:0] exp_region(input logic [31:0] x, input logic b,
                                              input logic en);
        if (b) begin
            if (x[31:24] == slot_decode_pkg::S1_CARD_IO[31:24]) return 3'h1;
            if (x[31:24] == slot_decode_pkg::S2_CARD_IO[31:24]) return 3'h1;
            if (x[31:24] == slot_decode_pkg::S1_CTRL[31:24]) return 3'h2;
            if (x[31:24] == slot_decode_pkg::S2_CTRL[31:24]) return 3'h2;
            if (x[31:25] == slot_decode_pkg::S1_CARD_ATTR[31:25]) return 3'h3;
            if (x[31:25] == slot_decode_pkg::S2_CARD_ATTR[31:25]) return 3'h3;
            return 3'h0;
        end
        if (x[31:26] == slot_decode_pkg::S1_DIRECT[31:26]) return 3'h4;
        if (x[31:26] == slot_decode_pkg::S2_DIRECT[31:26]) return 3'h4;
        if (x[31:27] == slot_decode_pkg::S1_CARD_IO[31:27]) return en ? 3'h7 : 3'h4;
        return 3'h0;
    endfunction : exp_region

    // Probe the combinational decode with strobes idle
    task automatic probe(input logic [31:0] x);
        logic [2:0] e;
        logic h;
        host.set_addr(x);
        @(negedge clock_in);
        e = exp_region(x, buffer_present_in, slot_io_space_enable_in);
        h = (e == 3'h2) || (e == 3'h4);
        if (e != 3'h7) chk("region", e, region);
        chk("hit", h, hit);
        chk("card_off", e == 3'h2, card_off);
        chk("reg_space", h && x[16:0] >= slot_decode_pkg::REG_FIRST, reg_sp);
    endtask : probe

    // Reset with given straps, then move the straps: outputs must not follow
    task automatic do_reset(input logic [3:0] s, input logic bs);
        @(posedge clock_in);
        arst_n_in <= 1'b0;
        config_straps_in <= s;
        bus_status_strap_in <= bs;
        repeat (20) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        config_straps_in <= ~s;
        bus_status_strap_in <= ~bs;
        repeat (3) @(negedge clock_in);
        chk("generic", s[2:0] == slot_decode_pkg::BUS_GENERIC, generic);
        chk("big_endian", s[3], big_end);
        chk("mode_two", bs == slot_decode_pkg::STATUS_MODE_TWO, mode_two);
    endtask : do_reset

    // One host access, checked against pacing and the word model
    task automatic do_access(input logic [31:0] x, input logic [15:0] d, input bit wr,
                             input logic [1:0] ln, input bit ok);
        logic [15:0] rd, m;
        int lead, held;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        host.access(x, d, wr, ln, rd, lead, held);
        if (!ok) begin
            chk("ignored", 10, lead);
        end else begin
            chk("sync_lead", 1, lead >= 2 && lead <= 5);
            chk("wait_len", slot_decode_pkg::ACCESS_CYC, held);
            if (!wr) chk("rdata", exp_mem[x[4:1]] & m, rd & m);
            if (wr && ln[0]) exp_mem[x[4:1]][7:0] = d[7:0];
            if (wr && ln[1]) exp_mem[x[4:1]][15:8] = d[15:8];
        end
    endtask : do_access

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 62;
        errors = 0;
        check_count = 0;
        arst_n_in = 1'b0;
        buffer_present_in = 1'b1;
        slot_io_space_enable_in = 1'b1;
        config_straps_in = 4'hF;
        bus_status_strap_in = 1'b0;
        // Straps: big endian, then non-generic mode two (refused), then mode one
        do_reset(4'hF, 1'b0);
        do_reset(4'h5, 1'b1);
        do_access(slot_decode_pkg::S1_CTRL, 16'h1234, 1'b1, 2'b11, 1'b0);
        do_reset(4'h7, 1'b0);
        $display("test straps done");
        // Decode: corners then random addresses, three map settings
        for (j = 0; j < 3; j++) begin
            buffer_present_in <= (j == 0);
            slot_io_space_enable_in <= (j == 2);
            for (i = 0; i < 26; i++) begin
                r = $random(seed);
                a = (r & 32'h07FF_FFFF) | (r[31] ? 32'h0800_0000 : 32'h6400_0000);
                if (i < 6) a = slot_decode_pkg::S1_CTRL + (i << 24) - i[0]; // Edges
                if (i == 6) a = slot_decode_pkg::S2_CTRL | 32'h00FF_FFFF;
                probe(a);
            end
        end
        $display("test decode done");
        // Fill every word with both lanes, then random aliased traffic
        buffer_present_in <= 1'b1;
        for (i = 0; i < 16; i++) do_access(slot_decode_pkg::S1_CTRL | (i << 1),
            16'($random(seed)), 1'b1, 2'b11, 1'b1);
        for (i = 0; i < 60; i++) begin
            r = $random(seed);
            a = r[31] ? {15'h0000, slot_decode_pkg::REG_FIRST[16:5], r[13:10], 1'b0}
                      : {16'h0000, r[25:11], 1'b0};
            buffer_present_in <= (i % 3 != 2);
            slot_io_space_enable_in <= 1'b0;
            if (i % 3 == 0) a = a | slot_decode_pkg::S1_CTRL | {8'h00, r[6:0], 17'h0_0000};
            if (i % 3 == 1) a = a | slot_decode_pkg::S2_CTRL | {8'h00, r[6:0], 17'h0_0000};
            if (i % 3 == 2) a = a | {r[30] ? 6'h19 : 6'h02, r[8:0], 17'h0_0000};
            do_access(a, 16'($random(seed)), r[29], (r[28:27] == 2'b00) ? 2'b11 : r[28:27],
                1'b1);
        end
        $display("test access done");
        buffer_present_in <= 1'b1;
        // Refused places: card IO, card attribute, card memory, IO space with enable set
        do_access(slot_decode_pkg::S1_CARD_IO, 16'hA5A5, 1'b1, 2'b11, 1'b0);
        do_access(slot_decode_pkg::S2_CARD_ATTR, 16'h0000, 1'b0, 2'b11, 1'b0);
        do_access(slot_decode_pkg::S1_DIRECT, 16'h5A5A, 1'b1, 2'b11, 1'b0);
        buffer_present_in <= 1'b0;
        slot_io_space_enable_in <= 1'b1;
        do_access(slot_decode_pkg::S1_CTRL, 16'h0F0F, 1'b1, 2'b11, 1'b0);
        do_reset(4'hF, 1'b1);
        do_access(slot_decode_pkg::S2_DIRECT, 16'hC3C3, 1'b1, 2'b11, 1'b1);
        do_access(slot_decode_pkg::S2_DIRECT, 16'h0000, 1'b0, 2'b11, 1'b1);
        $display("test refusal done");
        print_verdict();
    end
endmodule : testbench
